// ---- design/arms_pkg.sv ----
// arm sequencer package: register map, field layout, states, limits, timing
// assumes a 20 MHz aclk and an AXI4-Lite master with 32-bit data
package arms_pkg;

    // register byte offsets
    localparam logic [7:0] REG_CTRL      = 8'h00;
    localparam logic [7:0] REG_ARM_COUNT = 8'h04;
    localparam logic [7:0] REG_DELAY     = 8'h08;
    localparam logic [7:0] REG_POINTS    = 8'h0C;
    localparam logic [7:0] REG_CMD       = 8'h10;
    localparam logic [7:0] REG_STATUS    = 8'h14;
    localparam logic [7:0] REG_SEGMENT   = 8'h18;
    localparam logic [7:0] REG_REMAIN    = 8'h1C;
    localparam logic [7:0] REG_LIMIT     = 8'h20;
    localparam logic [7:0] REG_THRESH    = 8'h24;

    // control register fields
    localparam int CTRL_PREARM   = 0;
    localparam int CTRL_NVMEM    = 1;
    localparam int CTRL_EXPGEN   = 2;
    localparam int CTRL_EXPCONV  = 3;
    localparam int CTRL_ARMINF   = 4;
    localparam int CTRL_PTSINF   = 5;
    localparam int CTRL_SRC1_LSB = 8;
    localparam int CTRL_SLP1_LSB = 12;
    localparam int CTRL_SRC2_LSB = 16;
    localparam int CTRL_SLP2_LSB = 20;

    // command register bits (write-one pulses)
    localparam int CMD_BEGIN  = 0;
    localparam int CMD_HALT   = 1;
    localparam int CMD_FORCE  = 2;
    localparam int CMD_BURST  = 3;
    localparam int CMD_ERRCLR = 4;

    // status bits
    localparam int ST_STATE_LSB   = 0;
    localparam int ST_ERR_IGNORED = 4;
    localparam int ST_ERR_CONFLICT = 5;
    localparam int ST_ERR_POINTS  = 6;
    localparam int ST_ERR_COUNT   = 7;
    localparam int ST_WRAP        = 8;

    localparam logic [16:0] MAX_ARM_COUNT  = 17'h0FFFF;
    localparam logic [15:0] MIN_ARM_COUNT  = 16'h0001;
    localparam logic [15:0] PREARM_MAX_ARM = 16'h0080;
    localparam logic [19:0] MEM_READINGS   = 20'h80000;
    localparam logic [19:0] MIN_SEGMENT    = 20'h01000;
    localparam logic [19:0] NV_RESERVED    = 20'h00004;
    localparam logic [15:0] DELAY_RESET    = 16'h0000;
    localparam logic [16:0] FINE_DELAY_MAX = 17'h0FFFE;
    localparam logic [3:0]  COARSE_STEP    = 4'hA;

    // inherent arm-to-trigger latency
    localparam int INHERENT_NS     = 230;
    localparam int CLK_PERIOD_NS   = 50;
    localparam int INHERENT_CYCLES = (INHERENT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE      = 2'b00,
        ST_INITIATED = 2'b01,
        ST_WAIT_ARM  = 2'b10,
        ST_WAIT_TRIG = 2'b11
    } arms_state_t;

    typedef enum logic [3:0] {
        SRC_HOLD = 4'h0,
        SRC_IMM  = 4'h1,
        SRC_EXT1 = 4'h2,
        SRC_CH1  = 4'h3,
        SRC_CH2  = 4'h4,
        SRC_TTL  = 4'h5,
        SRC_ECL  = 4'h6,
        SRC_BUS  = 4'h7
    } arms_src_t;

    typedef enum logic [1:0] {
        SLP_POS    = 2'b00,
        SLP_NEG    = 2'b01,
        SLP_EITHER = 2'b10
    } arms_slope_t;

    // arm event inputs gathered
    typedef struct packed {
        logic       ext1;
        logic       ch1_rise;
        logic       ch1_fall;
        logic       ch2_rise;
        logic       ch2_fall;
        logic [7:0] ttl;
        logic [1:0] ecl;
        logic       bus;
    } arms_events_t;

endpackage : arms_pkg

// ---- design/arms_sequencer.sv ----
// arm sequencer: arm counting, memory partitioning, arm delay and force arm
// assumes AXI4-Lite master on aclk; arm event inputs synchronous, one-cycle pulses
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps

module arms_sequencer
    import arms_pkg::*;
(
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // axi4-lite write address, data and response
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    // arm event sources
    input  wire arms_events_t arm_events,
    // sequencer outputs
    output logic              trigger_armed,
    output logic              falling_arm_threshold_active,
    output logic [7:0]        segment_count,
    output logic              memory_wrap
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0]  ctrl;
    logic [15:0]  arm_count;
    logic [19:0]  delay_req;
    logic [19:0]  points;
    logic [15:0]  falling_arm_threshold;
    logic         err_ignored;
    logic         err_conflict;
    arms_state_t  state;
    logic [15:0]  arms_remaining;
    logic [19:0]  delay_cnt;
    logic [3:0]   tick_div;
    logic         delay_run;
    logic         force_pending;

    // axi
    logic         aw_held;
    logic         w_held;
    logic [7:0]   aw_addr;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         wr_go;

    ////////////////////////////////////////////////////////////////////////////
    // configuration decode
    logic        pre_arm;
    logic        nv_mem;
    logic        exp_conv;
    logic        arm_inf;
    logic        pts_inf;
    arms_src_t   src1;
    arms_src_t   src2;
    arms_slope_t slp1;
    arms_slope_t slp2;

    assign pre_arm  = ctrl[CTRL_PREARM];
    assign nv_mem   = ctrl[CTRL_NVMEM];
    assign exp_conv = ctrl[CTRL_EXPGEN] & ctrl[CTRL_EXPCONV];
    assign arm_inf  = ctrl[CTRL_ARMINF];
    assign pts_inf  = ctrl[CTRL_PTSINF];
    assign src1     = arms_src_t'(ctrl[CTRL_SRC1_LSB +: 4]);
    assign src2     = arms_src_t'(ctrl[CTRL_SRC2_LSB +: 4]);
    assign slp1     = arms_slope_t'(ctrl[CTRL_SLP1_LSB +: 2]);
    assign slp2     = arms_slope_t'(ctrl[CTRL_SLP2_LSB +: 2]);

    ////////////////////////////////////////////////////////////////////////////
    // memory partitioning and limits
    logic [7:0]  seg_cnt;
    logic [19:0] seg_size;
    logic [19:0] points_limit;
    logic [35:0] total_need;
    logic        err_points;
    logic        err_count;

    always_comb begin
        seg_cnt  = 8'h01;
        seg_size = MEM_READINGS;
        if (pre_arm && arm_count > MIN_ARM_COUNT) begin
            for (int i = 0; i < 7; i++) begin
                if ({8'h00, seg_cnt} < arm_count) begin
                    seg_cnt  = {seg_cnt[6:0], 1'b0};
                    seg_size = {1'b0, seg_size[19:1]};
                end
            end
        end
        if (seg_size < MIN_SEGMENT) begin
            seg_size = MIN_SEGMENT;
        end
    end

    assign points_limit = nv_mem ? seg_size - NV_RESERVED : seg_size;
    assign total_need   = arm_count * points;

    assign err_points = !pts_inf && points > points_limit;
    assign err_count  = (pre_arm && arm_count > PREARM_MAX_ARM)
                      || (!pre_arm && !exp_conv && !arm_inf && !pts_inf
                          && total_need > {16'h0000, MEM_READINGS});
    assign segment_count = seg_cnt;
    // wrap lets memory overwrite oldest data, read-back oldest first
    assign memory_wrap   = exp_conv || arm_inf || pts_inf;

    ////////////////////////////////////////////////////////////////////////////
    // arm delay rounding: fine range or coarse 10T range
    logic [19:0] delay_eff;
    logic [19:0] coarse_q;
    logic [19:0] coarse_rnd;

    always_comb begin
        coarse_q   = delay_req / 20'(COARSE_STEP);
        coarse_rnd = (delay_req % 20'(COARSE_STEP) >= 20'h00005) ? coarse_q + 20'h00001
                                                                 : coarse_q;
        if (pre_arm) begin
            delay_eff = 20'h00000;
        end else if (delay_req <= 20'(FINE_DELAY_MAX)) begin
            delay_eff = delay_req;
        end else begin
            // nearest of the fine top and the coarse grid
            delay_eff = coarse_rnd * 20'(COARSE_STEP);
            if (delay_eff < 20'h1000A && delay_req < 20'h10001) begin
                delay_eff = 20'(FINE_DELAY_MAX);
            end else if (delay_eff < 20'h10004) begin
                delay_eff = 20'h10004;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // arm event selection
    function automatic logic src_hit(arms_src_t s, arms_slope_t p, arms_events_t e);
        logic r;
        r = 1'b0;
        unique case (s)
            SRC_HOLD: r = 1'b0;
            SRC_IMM:  r = 1'b1;
            SRC_EXT1: r = e.ext1;
            SRC_CH1:  r = (p != SLP_NEG & e.ch1_rise) | (p != SLP_POS & e.ch1_fall);
            SRC_CH2:  r = (p != SLP_NEG & e.ch2_rise) | (p != SLP_POS & e.ch2_fall);
            SRC_TTL:  r = |e.ttl;
            SRC_ECL:  r = |e.ecl;
            SRC_BUS:  r = e.bus;
            default:  r = 1'b0;
        endcase
        return r;
    endfunction : src_hit

    logic arm_event;
    assign arm_event = src_hit(src1, slp1, arm_events)
                     | src_hit(src2, slp2, arm_events);

    assign falling_arm_threshold_active =
        ((src1 == SRC_CH1 || src1 == SRC_CH2) && slp1 != SLP_POS)
        || ((src2 == SRC_CH1 || src2 == SRC_CH2) && slp2 != SLP_POS);

    ////////////////////////////////////////////////////////////////////////////
    // axi write path
    logic [31:0] cmd;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    assign cmd   = (wr_go && aw_addr == REG_CMD && w_strb[0]) ? w_data : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_bresp   = 2'b00;

    // configuration is only writable while idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl                  <= {12'h000, 4'(SRC_HOLD), 4'h0, 4'(SRC_IMM), 8'h00};
            arm_count             <= MIN_ARM_COUNT;
            delay_req             <= {4'h0, DELAY_RESET};
            points                <= 20'h00001;
            falling_arm_threshold <= 16'h0000;
        end else if (wr_go && state == ST_IDLE) begin
            unique case (aw_addr)
                REG_CTRL:      ctrl <= w_data;
                REG_ARM_COUNT: begin
                    if (w_data[15:0] >= MIN_ARM_COUNT) begin
                        arm_count <= w_data[15:0];
                    end
                end
                REG_DELAY:     delay_req <= w_data[19:0];
                REG_POINTS:    points <= w_data[19:0];
                REG_THRESH:    falling_arm_threshold <= w_data[15:0];
                default:       ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    logic halt;
    logic force_cmd;
    logic delay_done;
    assign halt      = cmd[CMD_HALT];
    assign force_cmd = cmd[CMD_FORCE];
    assign delay_done = delay_cnt >= delay_eff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state          <= ST_IDLE;
            arms_remaining <= 16'h0000;
            force_pending  <= 1'b0;
        end else if (halt) begin
            state          <= ST_IDLE;
            force_pending  <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (cmd[CMD_BEGIN] && !err_points && !err_count) begin
                        state          <= ST_INITIATED;
                        arms_remaining <= arm_count;
                    end
                end
                ST_INITIATED: begin
                    if (!arm_inf && arms_remaining == 16'h0000) begin
                        state <= ST_IDLE;
                    end else if (pre_arm) begin
                        state <= ST_WAIT_TRIG;
                    end else begin
                        state <= ST_WAIT_ARM;
                    end
                end
                ST_WAIT_ARM: begin
                    if (force_cmd) begin
                        state <= ST_WAIT_TRIG;
                    end else if (delay_run && delay_done) begin
                        state <= ST_WAIT_TRIG;
                    end
                end
                ST_WAIT_TRIG: begin
                    if (cmd[CMD_BURST]) begin
                        state <= ST_INITIATED;
                        if (!arm_inf) begin
                            arms_remaining <= arms_remaining - 16'h0001;
                        end
                    end
                end
            endcase
        end
    end

    // arm delay counter, ticks every T or every 10T in the coarse range
    logic tick;
    assign tick = (delay_eff <= 20'(FINE_DELAY_MAX)) || tick_div == COARSE_STEP - 4'h1;

    always_ff @(posedge aclk) begin
        if (!aresetn || halt) begin
            delay_run <= 1'b0;
            delay_cnt <= 20'h00000;
            tick_div  <= 4'h0;
        end else if (state == ST_WAIT_ARM && !delay_run && arm_event && !force_cmd) begin
            delay_run <= 1'b1;
            delay_cnt <= 20'h00000;
            tick_div  <= 4'h0;
        end else if (delay_run && state == ST_WAIT_ARM && !delay_done) begin
            tick_div  <= tick ? 4'h0 : tick_div + 4'h1;
            if (tick) begin
                delay_cnt <= (delay_eff <= 20'(FINE_DELAY_MAX)) ? delay_cnt + 20'h00001
                                                                : delay_cnt + 20'(COARSE_STEP);
            end
        end else if (state != ST_WAIT_ARM) begin
            delay_run <= 1'b0;
        end
    end

    assign trigger_armed = state == ST_WAIT_TRIG;   // latency beyond delay

    // error flags: set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_ignored  <= 1'b0;
            err_conflict <= 1'b0;
        end else begin
            if (force_cmd && (state == ST_IDLE || state == ST_WAIT_TRIG)) begin
                err_ignored <= 1'b1;
            end else if (cmd[CMD_ERRCLR]) begin
                err_ignored <= 1'b0;
            end
            if (pre_arm && delay_req != 20'h00000) begin
                err_conflict <= 1'b1;
            end else if (cmd[CMD_ERRCLR]) begin
                err_conflict <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi read path
    logic [31:0] rd_mux;
    always_comb begin
        unique case (s_axi_araddr)
            REG_CTRL:      rd_mux = ctrl;
            REG_ARM_COUNT: rd_mux = {16'h0000, arm_count};
            REG_DELAY:     rd_mux = {12'h000, delay_eff};
            REG_POINTS:    rd_mux = {12'h000, points};
            REG_STATUS:    rd_mux = {23'h0, memory_wrap, err_count, err_points,
                                     err_conflict, err_ignored, 2'b00, state};
            REG_SEGMENT:   rd_mux = {24'h000000, seg_cnt};
            REG_REMAIN:    rd_mux = {16'h0000, arms_remaining};
            REG_LIMIT:     rd_mux = {12'h000, points_limit};
            REG_THRESH:    rd_mux = {16'h0000, falling_arm_threshold};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp   = 2'b00;

endmodule : arms_sequencer

// ---- verif/arm_sequencer_tb_top.sv ----
// self-checking bench for the arm sequencer
// assumes the design, checker and event source model are compiled first
`timescale 1ns/100ps
module arm_sequencer_tb_top
    import arms_pkg::*;
;
    logic         aclk = 1'b0, aresetn = 1'b0, ev_fire = 1'b0;
    logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, seg;
    logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, exp_q[$], mask_q[$];
    logic [3:0]   s_axi_wstrb = 4'hF, ev_lag = 4'h0;
    logic         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic         s_axi_bvalid, s_axi_arready, s_axi_rvalid, trigger_armed, memory_wrap;
    logic         falling_arm_threshold_active;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic [7:0]   segment_count;
    arms_events_t arm_events;
    arms_src_t    ev_kind = SRC_EXT1;
    int           err_total = 0, checks = 0, cyc_cnt = 0, n, nv;
    int unsigned  dly_in[5] = '{100, 65534, 65538, 70006, 655350};
    int unsigned  dly_out[5] = '{100, 65534, 65540, 70010, 655350};

    arms_sequencer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .arm_events, .trigger_armed,
        .falling_arm_threshold_active, .segment_count, .memory_wrap);
    arms_event_src ev_u (.aclk, .fire(ev_fire), .kind(ev_kind), .lag(ev_lag), .arm_events);

    always #25 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] seg_of(input int c);
        seg_of = 8'h01;
        while (seg_of < c) seg_of = seg_of << 1;
    endfunction : seg_of

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back(e & m);
        mask_q.push_back(m);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic fire_ev(input arms_src_t k, input logic [3:0] l);
        ev_kind <= k;
        ev_lag <= l;
        ev_fire <= 1'b1;
        @(posedge aclk);
        ev_fire <= 1'b0;
    endtask : fire_ev

    task automatic wait_trig(output int c);
        c = 0;
        do begin
            @(negedge aclk);
            c++;
        end while (trigger_armed !== 1'b1 && c < 1000);
        @(posedge aclk);
    endtask : wait_trig

    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) check(s_axi_rdata & mask_q.pop_front(), exp_q.pop_front());
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(20));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(REG_ARM_COUNT, 32'hFFFF, 32'h1);
        rd(REG_DELAY, 32'hFFFFFFFF, 32'h0);
        rd(8'h3C, 32'hFFFFFFFF, 32'h0);
        wr(REG_ARM_COUNT, 32'h0);
        rd(REG_ARM_COUNT, 32'hFFFF, 32'h1);
        wr(REG_ARM_COUNT, 32'hFFFF);
        rd(REG_ARM_COUNT, 32'hFFFF, 32'hFFFF);
        foreach (dly_in[i]) begin
            wr(REG_DELAY, dly_in[i]);
            rd(REG_DELAY, 32'hFFFFF, dly_out[i]);
        end
        for (int i = 0; i < 6; i++) begin
            n = (i == 0) ? 128 : $urandom_range(128, 2);
            nv = i % 2;
            wr(REG_CTRL, 32'h101 | 32'(nv << 1));
            wr(REG_ARM_COUNT, 32'(n));
            seg = seg_of(n);
            rd(REG_SEGMENT, 32'hFF, {24'h0, seg});
            rd(REG_LIMIT, 32'hFFFFF, 32'(MEM_READINGS / seg) - 32'(nv * 4));
            check({24'h0, segment_count}, {24'h0, seg});
        end
        wr(REG_DELAY, 32'h64);
        rd(REG_DELAY, 32'hFFFFF, 32'h0);
        rd(REG_STATUS, 32'h20, 32'h20);
        wr(REG_CTRL, 32'h1300);
        check({31'h0, falling_arm_threshold_active}, 32'h1);
        wr(REG_CTRL, 32'h240200);
        check({31'h0, falling_arm_threshold_active}, 32'h1);
        wr(REG_CTRL, 32'h50200);
        check({31'h0, falling_arm_threshold_active}, 32'h0);
        wr(REG_ARM_COUNT, 32'h3);
        wr(REG_DELAY, 32'h0);
        wr(REG_POINTS, 32'h10);
        wr(REG_CMD, 32'h10);
        wr(REG_CMD, 32'h1);
        rd(REG_STATUS, 32'h3, 32'h2);
        fire_ev(SRC_TTL, 4'($urandom_range(9, 0)));
        wait_trig(n);
        rd(REG_STATUS, 32'h3, 32'h3);
        wr(REG_CMD, 32'h8);
        rd(REG_STATUS, 32'h3, 32'h2);
        wr(REG_CMD, 32'h4);
        rd(REG_STATUS, 32'h3, 32'h3);
        wr(REG_CMD, 32'h4);
        rd(REG_STATUS, 32'h13, 32'h13);
        wr(REG_CMD, 32'h8);
        fire_ev(SRC_EXT1, 4'h3);
        wait_trig(n);
        rd(REG_STATUS, 32'h3, 32'h3);
        wr(REG_CMD, 32'h8);
        rd(REG_STATUS, 32'h3, 32'h0);
        wr(REG_CMD, 32'h10);
        wr(REG_CMD, 32'h4);
        rd(REG_STATUS, 32'h10, 32'h10);
        wr(REG_ARM_COUNT, 32'h2);
        wr(REG_DELAY, 32'h28);
        wr(REG_CMD, 32'h1);
        fire_ev(SRC_EXT1, 4'h0);
        repeat (10) @(posedge aclk);
        wr(REG_CMD, 32'h2);
        wr(REG_CMD, 32'h1);
        fire_ev(SRC_EXT1, 4'h0);
        wait_trig(n);
        check(32'(n >= 40 && n <= 40 + INHERENT_CYCLES + 8), 32'h1);
        wr(REG_CMD, 32'h8);
        wr(REG_CMD, 32'h4);
        rd(REG_STATUS, 32'h3, 32'h3);
        wr(REG_CMD, 32'h2);
        wr(REG_CTRL, 32'h210);
        check({31'h0, memory_wrap}, 32'h1);
        wr(REG_CMD, 32'h1);
        repeat (2) begin
            wr(REG_CMD, 32'h4);
            wr(REG_CMD, 32'h8);
        end
        rd(REG_STATUS, 32'h3, 32'h2);
        wr(REG_CMD, 32'h2);
        rd(REG_STATUS, 32'h3, 32'h0);
        wr(REG_CTRL, 32'h20C);
        check({31'h0, memory_wrap}, 32'h1);
        print_verdict();
    end
endmodule : arm_sequencer_tb_top

// ---- verif/arms_event_src.sv ----
// arm event source model: one pulse on a chosen line per request
// assumes requests change just after a rising edge of aclk
`timescale 1ns/100ps
module arms_event_src
    import arms_pkg::*;
(
    // requests from the bench
    input  wire logic       aclk,
    input  wire logic       fire,
    input  wire arms_src_t  kind,
    input  wire logic [3:0] lag,
    // event lines
    output arms_events_t    arm_events = '0
);
    logic       pending = 1'b0;
    logic [3:0] wait_cnt = 4'h0;
    // one-cycle pulses: a held level would arm again at once
    always @(posedge aclk) begin
        arm_events <= '0;
        if (fire) begin
            pending <= 1'b1;
            wait_cnt <= lag;
        end else if (pending && wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else if (pending) begin
            pending <= 1'b0;
            case (kind)
                SRC_EXT1: arm_events.ext1 <= 1'b1;
                SRC_TTL:  arm_events.ttl <= 8'h80;
                default:  arm_events.bus <= 1'b1;
            endcase
        end
    end
endmodule : arms_event_src

// ---- verif/arms_sequencer_props.sv ----
// checker for the arm sequencer ports
// assumes one aclk domain with synchronous active-low aresetn
`timescale 1ns/100ps
module arms_sequencer_props
    import arms_pkg::*;
(
    // clock and reset
    input wire logic         aclk,
    input wire logic         aresetn,
    // register bus
    input wire logic [7:0]   s_axi_awaddr,
    input wire logic         s_axi_awvalid,
    input wire logic         s_axi_awready,
    input wire logic [31:0]  s_axi_wdata,
    input wire logic [3:0]   s_axi_wstrb,
    input wire logic         s_axi_wvalid,
    input wire logic         s_axi_wready,
    input wire logic [1:0]   s_axi_bresp,
    input wire logic         s_axi_bvalid,
    input wire logic         s_axi_bready,
    input wire logic [7:0]   s_axi_araddr,
    input wire logic         s_axi_arvalid,
    input wire logic         s_axi_arready,
    input wire logic [31:0]  s_axi_rdata,
    input wire logic [1:0]   s_axi_rresp,
    input wire logic         s_axi_rvalid,
    input wire logic         s_axi_rready,
    // events and sequencer outputs
    input wire arms_events_t arm_events,
    input wire logic         trigger_armed,
    input wire logic         falling_arm_threshold_active,
    input wire logic [7:0]   segment_count,
    input wire logic         memory_wrap
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    property p_reset_clear;
        $rose(aresetn) |-> !trigger_armed && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset state");
    property p_seg_pow2;
        $onehot(segment_count) && segment_count <= 8'h80;
    endproperty
    a_seg_pow2: assert property (p_seg_pow2)
        else $error("segment count");
    // only a burst end or halt command leaves wait-for-trigger
    property p_armed_exit;
        $fell(trigger_armed) |-> $rose(s_axi_bvalid);
    endproperty
    a_armed_exit: assert property (p_armed_exit)
        else $error("armed exit");
    property p_cfg_frozen;
        trigger_armed |=> $stable(falling_arm_threshold_active) && $stable(memory_wrap)
            && $stable(segment_count);
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen)
        else $error("config moved");
    property p_bvalid_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold)
        else $error("bvalid dropped");
    property p_rvalid_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rvalid_hold: assert property (p_rvalid_hold)
        else $error("rdata moved");
    property p_resp_okay;
        s_axi_bvalid || s_axi_rvalid |-> s_axi_bresp == 2'b00 && s_axi_rresp == 2'b00;
    endproperty
    a_resp_okay: assert property (p_resp_okay)
        else $error("resp not okay");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready;
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read late");
    c_armed: cover property ($rose(trigger_armed));
    c_wrap: cover property ($rose(memory_wrap));
    c_falling: cover property ($rose(falling_arm_threshold_active));
endmodule : arms_sequencer_props

bind arms_sequencer arms_sequencer_props u_props (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .arm_events, .trigger_armed,
    .falling_arm_threshold_active, .segment_count, .memory_wrap
);
